//--- hw/bsc_pkg.sv
/*
 bsc_pkg: constants shared by the byte stream checksum unit and its fifo.
 assumes a single system clock and a processor-side writer on that clock.
*/
package bsc_pkg;
   localparam int BSC_DATA_W = 8;          // one input byte per write
   localparam int BSC_FIFO_DEPTH = 8;      // input words buffered
   localparam int BSC_PTR_W = 2;           // selects one of four result bytes
   localparam logic [15:0] BSC_POLY16 = 16'h1021;
   localparam logic [31:0] BSC_POLY32 = 32'h04c11db7;
   localparam logic [31:0] BSC_INIT_ZERO = 32'h00000000;
   localparam logic [31:0] BSC_INIT_ONES = 32'hffffffff;
   localparam logic [31:0] BSC_RESULT_RST = 32'h00000000;
   localparam logic [1:0] BSC_PTR_RST = 2'h0;
   localparam logic [7:0] BSC_BYTE_RST = 8'h00;
   localparam int BSC_BITS_PER_BYTE = 8;   // shift steps per byte
endpackage

//--- hw/bsc_fifo.sv
/*
 bsc_fifo: synchronous fifo with valid/ready on both sides.
 assumes one clock; the drain side may hold out_ready low to stall it.
*/
`timescale 1ns/1ns
module bsc_fifo
   import bsc_pkg::*;
#(
   parameter int WIDTH = BSC_DATA_W,
   parameter int DEPTH = BSC_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic push;
   logic pop;

   // ready is registered so the top can present it straight from a flop
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + CW'(1);
      end else if (pop && !push) begin
         next_count = count - CW'(1);
      end
   end

   // storage carries no reset; only valid entries are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
         end
         count <= next_count;
         in_ready <= (next_count != CW'(DEPTH));
      end
   end
endmodule // bsc_fifo

//--- hw/bsc_crc_unit.sv
/*
 bsc_crc_unit: byte stream checksum unit with indirect result access and a
 bit reversal helper.
 assumes every input comes from logic on CLK; strobes are one-cycle pulses.
*/
// How it works
// - MODE_32 picks the 32-bit polynomial, otherwise the 16-bit one.
// - each accepted IN_VALID/IN_DATA byte feeds exactly one byte update.
// - the running checksum lives in an internal 32-bit result register.
// - the byte pointer loaded by PTR_WR selects a result byte read on RES_DATA or written by RES_WR; RESULT_PTR shows it a cycle later.
// - a REV_WR byte comes back bit reversed on REV_DATA.
// - in 16-bit mode the update is msb first with polynomial 0x1021.
// - INIT presets the result to all zeros or, with INIT_ONES, all ones in 32-bit mode and 0x0000ffff in 16-bit mode.
// - each byte is first xored into the top byte of the checksum: result bits 31:24 in 32-bit mode, bits 15:8 in 16-bit mode.
// - per step, shift left and xor the polynomial when the top bit was set.
// - the shift step runs eight times per byte.
`timescale 1ns/1ns
module bsc_crc_unit
   import bsc_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic MODE_32,
   input wire logic INIT_ONES,
   input wire logic INIT,
   input wire logic IN_VALID,
   input wire logic [7:0] IN_DATA,
   output logic IN_READY,
   input wire logic PTR_WR,
   input wire logic [1:0] PTR_DATA,
   output logic [1:0] RESULT_PTR,
   input wire logic RES_WR,
   input wire logic [7:0] RES_WDATA,
   output logic [7:0] RES_DATA,
   input wire logic REV_WR,
   input wire logic [7:0] REV_WDATA,
   output logic [7:0] REV_DATA
);
   logic [31:0] result;
   logic [31:0] next_result;
   logic [1:0] result_byte_pointer;
   logic fifo_valid;
   logic [7:0] fifo_data;
   logic fifo_take;
   logic [7:0] rev_bits;

   // one byte through eight shift steps, combinational so it fits a cycle
   function automatic logic [31:0] fold_byte(input logic [31:0] cur,
                                             input logic [7:0] din,
                                             input logic wide);
      logic [31:0] c;
      logic [15:0] c16;
      c = cur ^ {din, 24'h000000};
      c16 = cur[15:0] ^ {din, 8'h00};
      for (int i = 0; i < BSC_BITS_PER_BYTE; i++) begin
         if (c[31]) begin
            c = {c[30:0], 1'b0} ^ BSC_POLY32;
         end else begin
            c = {c[30:0], 1'b0};
         end
         if (c16[15]) begin
            c16 = {c16[14:0], 1'b0} ^ BSC_POLY16;
         end else begin
            c16 = {c16[14:0], 1'b0};
         end
      end
      // upper half stays clear in 16-bit mode so byte reads are clean
      return wide ? c : {16'h0000, c16};
   endfunction

   // the processor's byte stream is buffered ahead of the update stage
   bsc_fifo #(
      .WIDTH(BSC_DATA_W),
      .DEPTH(BSC_FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK),
      .resetn(RESETN),
      .in_valid(IN_VALID),
      .in_data(IN_DATA),
      .in_ready(IN_READY),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(!(INIT || RES_WR))
   );

   // the update stage only yields to a preset or a direct byte write,
   // which would otherwise race the fold for the same register
   assign fifo_take = fifo_valid && !INIT && !RES_WR;

   always_comb begin
      next_result = result;
      if (INIT) begin
         next_result = INIT_ONES ? BSC_INIT_ONES : BSC_INIT_ZERO;
         if (!MODE_32) begin
            next_result[31:16] = 16'h0000;
         end
      end else if (RES_WR) begin
         next_result[result_byte_pointer*8 +: 8] = RES_WDATA;
      end else if (fifo_take) begin
         next_result = fold_byte(result, fifo_data, MODE_32);
      end
   end

   // running checksum register
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         result <= BSC_RESULT_RST;
      end else begin
         result <= next_result;
      end
   end

   // byte pointer for indirect access
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         result_byte_pointer <= BSC_PTR_RST;
      end else if (PTR_WR) begin
         result_byte_pointer <= PTR_DATA;
      end
   end

   // read port mirrors the selected byte one cycle after any change
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         RES_DATA <= BSC_BYTE_RST;
         RESULT_PTR <= BSC_PTR_RST;
      end else begin
         RES_DATA <= result[result_byte_pointer*8 +: 8];
         RESULT_PTR <= result_byte_pointer;
      end
   end

   // bit reversal is a pure rewiring, one wire per bit
   for (genvar b = 0; b < 8; b++) begin : g_rev
      assign rev_bits[b] = REV_WDATA[7-b];
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         REV_DATA <= BSC_BYTE_RST;
      end else if (REV_WR) begin
         REV_DATA <= rev_bits;
      end
   end
endmodule // bsc_crc_unit

//--- test/bsc_crc_unit_monitor.sv
/* checker on the checksum unit ports
 assumes it is bound onto bsc_crc_unit */
`timescale 1ns/1ns
module bsc_crc_unit_monitor (
   input wire logic CLK, RESETN, MODE_32, INIT_ONES, INIT, IN_VALID,
   input wire logic IN_READY, PTR_WR, RES_WR, REV_WR,
   input wire logic [1:0] PTR_DATA, RESULT_PTR,
   input wire logic [7:0] RES_WDATA, RES_DATA, REV_WDATA, REV_DATA
);
   logic [7:0] rev_w;
   // the written byte as it should come back
   always_comb for (int k = 0; k < 8; k++) rev_w[k] = REV_WDATA[7-k];
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   rev_load_a:
      assert property (REV_WR |=> REV_DATA == $past(rev_w)) else $error("a");
   rev_hold_a:
      assert property (!REV_WR |=> $stable(REV_DATA)) else $error("b");
   ptr_load_a:
      assert property (PTR_WR |-> ##2 RESULT_PTR == $past(PTR_DATA, 2))
      else $error("c");
   ptr_hold_a:
      assert property (!PTR_WR [*2] |=> $stable(RESULT_PTR)) else $error("d");
   init_zero_a:
      assert property (INIT && !INIT_ONES |-> ##2 RES_DATA == 8'h00)
      else $error("e");
   init_ones_a:
      assert property (INIT && INIT_ONES && MODE_32 |-> ##2 RES_DATA == 8'hff)
      else $error("f");
   byte_write_a:
      assert property (RES_WR && !INIT && !PTR_WR |->
         ##2 RES_DATA == $past(RES_WDATA, 2)) else $error("g");
   ready_fall_a:
      assert property ($fell(IN_READY) |-> $past(IN_VALID)) else $error("h");
endmodule // bsc_crc_unit_monitor

//--- test/bsc_byte_src.sv
/* processor side model that writes input bytes
 assumes send is called just after a rising clk edge */
`timescale 1ns/1ns
module bsc_byte_src (
   input wire logic clk, ready,
   output logic valid,
   output logic [7:0] data
);
   initial valid = 1'h0;
   initial data = 8'h00;
   // one write per byte, held until the edge that takes it
   task automatic send(input logic [7:0] b);
      logic take;
      take = 1'h0;
      valid = 1'h1;
      data = b;
      for (int i = 0; i < 200 && !take; i++) begin
         take = (ready === 1'h1);
         @(posedge clk);
         #1;
      end
   endtask
   // released bus shows no stale byte
   task automatic idle();
      valid = 1'h0;
      data = ~data;
   endtask
endmodule // bsc_byte_src

//--- test/bsc_crc_unit_tb_top.sv
/* bench for the checksum unit
 assumes the byte source and monitor are compiled first */
`timescale 1ns/1ns
module bsc_crc_unit_tb_top import bsc_pkg::*; ;
   logic CLK = 1'h0, RESETN = 1'h0, MODE_32 = 1'h0, INIT_ONES = 1'h0;
   logic INIT = 1'h0, PTR_WR = 1'h0, RES_WR = 1'h0, REV_WR = 1'h0;
   logic IN_VALID, IN_READY;
   logic [1:0] PTR_DATA = 2'h0, RESULT_PTR;
   logic [7:0] RES_WDATA = 8'h00, REV_WDATA = 8'h00;
   logic [7:0] IN_DATA, RES_DATA, REV_DATA;
   int num_errors = 0, samples_checked = 0, cycles = 0;
   logic [31:0] st, got;
   always #2 CLK = ~CLK;
   bsc_crc_unit bsc_crc_unit_i (.*);
   bsc_byte_src bsc_byte_src_i (.clk(CLK), .ready(IN_READY),
      .valid(IN_VALID), .data(IN_DATA));
   task automatic tick(int n = 1);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic check(string nm, logic [31:0] exp, logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   // reference fold; 16-bit mode keeps the upper half clear
   function automatic logic [31:0] fold(logic [31:0] s, logic [7:0] b,
      logic w);
      s = w ? s ^ {b, 24'h0} : {16'h0, s[15:0] ^ {b, 8'h0}};
      for (int i = 0; i < 8; i++)
         if (w) s = {s[30:0], 1'h0} ^ (s[31] ? BSC_POLY32 : 32'h0);
         else s[15:0] = {s[14:0], 1'h0} ^ (s[15] ? BSC_POLY16 : 16'h0);
      return s;
   endfunction
   task automatic read_res(output logic [31:0] r);
      for (int k = 0; k < 4; k++) begin
         PTR_WR = 1'h1;
         PTR_DATA = k[1:0];
         tick();
         PTR_WR = 1'h0;
         tick(3);
         check("pointer", k, RESULT_PTR);
         r[8*k +: 8] = RES_DATA;
      end
   endtask
   task automatic start(logic w, logic ones);
      MODE_32 = w;
      INIT_ONES = ones;
      INIT = 1'h1;
      tick();
      INIT = 1'h0;
      st = ones ? (w ? BSC_INIT_ONES : 32'h0000ffff) : BSC_INIT_ZERO;
   endtask
   task automatic test_rev();
      for (int i = 0; i < 8; i++) begin
         REV_WR = 1'h1;
         REV_WDATA = 8'h01 << i;
         tick();
         check("reversed", 8'h80 >> i, REV_DATA);
      end
      REV_WR = 1'h0;
      REV_WDATA = 8'hff;
      tick();
      check("held", 8'h01, REV_DATA);
      $display("reverse done");
   endtask
   // every mode and preset, bytes back to back
   task automatic test_modes();
      for (int m = 0; m < 4; m++) begin
         start(m[1], m[0]);
         for (int i = 0; i < 9; i++) begin
            bsc_byte_src_i.send(8'h31 + i[7:0]);
            st = fold(st, 8'h31 + i[7:0], m[1]);
         end
         bsc_byte_src_i.idle();
         tick(2);
         read_res(got);
         check("crc", st, got);
      end
      $display("modes done");
   endtask
   // held preset stalls the fold so the fifo fills and refuses
   task automatic test_full();
      MODE_32 = 1'h1;
      INIT_ONES = 1'h0;
      INIT = 1'h1;
      st = BSC_INIT_ZERO;
      fork
         for (int i = 0; i < 10; i++) begin
            bsc_byte_src_i.send(8'h90 + i[7:0]);
            st = fold(st, 8'h90 + i[7:0], 1'h1);
         end
         begin
            tick(12);
            check("ready", 1'h0, IN_READY);
            INIT = 1'h0;
         end
      join
      bsc_byte_src_i.idle();
      // seven bytes are still queued here and drain one per cycle
      tick(12);
      read_res(got);
      check("drained", st, got);
      $display("fifo done");
   endtask
   // byte write uses the old pointer, then a fold cancels the top byte
   task automatic test_preload();
      start(1'h1, 1'h0);
      RES_WR = 1'h1;
      RES_WDATA = 8'h5a;
      PTR_WR = 1'h1;
      PTR_DATA = 2'h0;
      tick();
      PTR_WR = 1'h0;
      // a lone byte write now lands in byte 0 through the new pointer
      RES_WDATA = 8'ha5;
      tick();
      RES_WR = 1'h0;
      bsc_byte_src_i.send(8'h5a);
      bsc_byte_src_i.idle();
      tick(2);
      read_res(got);
      check("preload", fold(32'h5a0000a5, 8'h5a, 1'h1), got);
      $display("preload done");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // hang guard
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      tick(20);
      RESETN = 1'h1;
      tick(2);
      test_rev();
      test_modes();
      test_full();
      test_preload();
      stop_test();
   end
endmodule // bsc_crc_unit_tb_top
bind bsc_crc_unit bsc_crc_unit_monitor bsc_crc_unit_monitor_i (.*);
